/* hw/lit_counter.sv */
// One 16-bit down counter channel with mode logic, latches and byte sequencing.
`timescale 1ns/1ps
`default_nettype none
module lit_counter
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       tick,
   input  wire logic       gate,
   input  wire logic       ctrl_wr,
   input  wire logic [7:0] ctrl_data,
   input  wire logic       latch_cnt,
   input  wire logic       latch_st,
   input  wire logic       data_wr,
   input  wire logic       data_rd,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   output logic            out
);

   logic [1:0]  acc_ff;
   logic [2:0]  mode_ff;
   logic        bcd_ff;
   logic [15:0] init_ff;
   logic [15:0] cnt_ff;
   logic        out_ff;
   logic        null_ff;
   logic        load_pend_ff;
   logic        armed_ff;
   logic        wr_hi_ff;
   logic        rd_hi_ff;
   logic [15:0] lcnt_ff;
   logic        lcnt_v_ff;
   logic        lcnt_hi_ff;
   logic [7:0]  lst_ff;
   logic        lst_v_ff;
   logic        gate_d_ff;
   logic [15:0] nxt_cnt;
   logic [1:0]  step;
   logic        gate_rise;

   // Decrement by one or two, in binary or in four BCD digits.
   function automatic logic [15:0] dec(input logic [15:0] v, input logic [1:0] s,
                                       input logic b);
      logic [15:0] r;
      r = v - {14'h0000, s};
      if (b)
      begin
         r = v;
         for (int i = 0; i < 2; i++)
         begin
            if (i < int'(s))
            begin
               if (r[3:0] != 4'h0) r[3:0] = r[3:0] - 4'h1;
               else if (r[7:4] != 4'h0) r = {r[15:8], r[7:4] - 4'h1, 4'h9};
               else if (r[11:8] != 4'h0) r = {r[15:12], r[11:8] - 4'h1, 8'h99};
               else if (r[15:12] != 4'h0) r = {r[15:12] - 4'h1, 12'h999};
               else r = 16'h9999;
            end
         end
      end
      return r;
   endfunction

   assign gate_rise = gate && !gate_d_ff;
   assign step = (mode_ff[1:0] == lit_pkg::MODE_SQUARE[1:0]) ? 2'h2 : 2'h1;
   assign nxt_cnt = dec(cnt_ff, step, bcd_ff);

   // Programming: control word, count bytes in the selected format.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         acc_ff <= lit_pkg::ACC_LSB;
         mode_ff <= lit_pkg::MODE_EOC;
         bcd_ff <= 1'b0;
         init_ff <= 16'h0000;
         wr_hi_ff <= 1'b0;
         load_pend_ff <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         acc_ff <= ctrl_data[lit_pkg::ACC_HI:lit_pkg::ACC_LO];
         mode_ff <= {ctrl_data[lit_pkg::MODE_HI] & ~ctrl_data[lit_pkg::MODE_LO+1],
                     ctrl_data[lit_pkg::MODE_LO+1:lit_pkg::MODE_LO]};
         bcd_ff <= ctrl_data[lit_pkg::BCD_BIT];
         wr_hi_ff <= 1'b0;
         load_pend_ff <= 1'b0;
      end
      else
      begin
         if (data_wr)
         begin
            // Mode stays as programmed; only the count changes.
            case (acc_ff)
               lit_pkg::ACC_LSB:
               begin
                  init_ff <= {8'h00, wdata};
                  load_pend_ff <= 1'b1;
               end
               lit_pkg::ACC_MSB:
               begin
                  init_ff <= {wdata, 8'h00};
                  load_pend_ff <= 1'b1;
               end
               default:
               begin
                  if (wr_hi_ff) init_ff[15:8] <= wdata;
                  else init_ff[7:0] <= wdata;
                  load_pend_ff <= wr_hi_ff;
                  wr_hi_ff <= !wr_hi_ff;
               end
            endcase
         end
         else if (tick && load_pend_ff)
            load_pend_ff <= 1'b0;
      end
   end

   // Counting element and output waveform for all six modes.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cnt_ff <= 16'h0000;
         out_ff <= 1'b0;
         null_ff <= 1'b1;
         armed_ff <= 1'b0;
         gate_d_ff <= 1'b0;
      end
      else
      begin
         gate_d_ff <= gate;
         if (ctrl_wr)
         begin
            // Modes 0 and 1 start low, the others idle high.
            out_ff <= (ctrl_data[lit_pkg::MODE_HI:lit_pkg::MODE_LO+1] != 2'h0);
            null_ff <= 1'b1;
            armed_ff <= 1'b0;
         end
         else if (mode_ff == lit_pkg::MODE_ONESHOT || mode_ff == lit_pkg::MODE_HWSTB)
         begin
            // Hardware modes take the new count at a gate rising edge.
            if (gate_rise && !load_pend_ff)
            begin
               cnt_ff <= init_ff;
               armed_ff <= 1'b1;
               null_ff <= 1'b0;
               out_ff <= (mode_ff == lit_pkg::MODE_HWSTB);
            end
            else if (tick)
            begin
               if (mode_ff == lit_pkg::MODE_ONESHOT) out_ff <= 1'b0;
               else out_ff <= 1'b1;
               if (armed_ff)
               begin
                  cnt_ff <= nxt_cnt;
                  if (nxt_cnt == 16'h0000)
                  begin
                     out_ff <= (mode_ff == lit_pkg::MODE_ONESHOT);
                     armed_ff <= 1'b0;
                  end
               end
            end
         end
         else if (tick)
         begin
            if (load_pend_ff)
            begin
               cnt_ff <= init_ff;
               null_ff <= 1'b0;
               armed_ff <= 1'b1;
               if (mode_ff == lit_pkg::MODE_EOC) out_ff <= 1'b0;
            end
            else if (armed_ff && gate)
            begin
               cnt_ff <= nxt_cnt;
               case (mode_ff)
                  lit_pkg::MODE_EOC:
                     if (nxt_cnt == 16'h0000) out_ff <= 1'b1;
                  lit_pkg::MODE_RATE:
                  begin
                     out_ff <= (nxt_cnt != 16'h0001);
                     if (nxt_cnt == 16'h0000) cnt_ff <= init_ff;
                  end
                  lit_pkg::MODE_SQUARE, 3'h7:
                     if (nxt_cnt == 16'h0000 || cnt_ff == 16'h0001)
                     begin
                        cnt_ff <= init_ff;
                        out_ff <= !out_ff;
                     end
                  lit_pkg::MODE_SWSTB:
                  begin
                     out_ff <= (nxt_cnt != 16'h0000);
                     if (nxt_cnt == 16'h0000) armed_ff <= 1'b0;
                  end
                  default:
                     out_ff <= out_ff;
               endcase
            end
            else if (mode_ff == lit_pkg::MODE_SWSTB) out_ff <= 1'b1;
         end
      end
   end

   // Count and status latches; first latch wins until read.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         lcnt_ff <= 16'h0000;
         lcnt_v_ff <= 1'b0;
         lst_ff <= 8'h00;
         lst_v_ff <= 1'b0;
         lcnt_hi_ff <= 1'b0;
         rd_hi_ff <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         lcnt_v_ff <= 1'b0;
         lst_v_ff <= 1'b0;
         lcnt_hi_ff <= 1'b0;
         rd_hi_ff <= 1'b0;
      end
      else
      begin
         if (latch_cnt && !lcnt_v_ff)
         begin
            lcnt_ff <= cnt_ff;
            lcnt_v_ff <= 1'b1;
            lcnt_hi_ff <= 1'b0;
         end
         if (latch_st && !lst_v_ff)
         begin
            lst_ff <= {out_ff, null_ff, acc_ff, mode_ff, bcd_ff};
            lst_v_ff <= 1'b1;
         end
         if (data_rd)
         begin
            // Status first, then the latched count, then live count.
            if (lst_v_ff) lst_v_ff <= 1'b0;
            else if (lcnt_v_ff)
            begin
               if (acc_ff != lit_pkg::ACC_WORD || lcnt_hi_ff)
               begin
                  lcnt_v_ff <= 1'b0;
                  lcnt_hi_ff <= 1'b0;
               end
               else lcnt_hi_ff <= 1'b1;
            end
            else if (acc_ff == lit_pkg::ACC_WORD) rd_hi_ff <= !rd_hi_ff;
         end
      end
   end

   // Read data is registered from the selected source.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst) rdata <= 8'h00;
      else if (lst_v_ff) rdata <= lst_ff;
      else if (lcnt_v_ff)
         rdata <= (acc_ff == lit_pkg::ACC_MSB || lcnt_hi_ff) ? lcnt_ff[15:8] : lcnt_ff[7:0];
      else
         rdata <= (acc_ff == lit_pkg::ACC_MSB || rd_hi_ff) ? cnt_ff[15:8] : cnt_ff[7:0];
   end

   assign out = out_ff;

endmodule
`default_nettype wire

/* hw/lit_pkg.sv */
// Package with the register map, field layout and timing constants of the interval timer.
package lit_pkg;

   // Port addresses on the byte-wide I/O bus.
   localparam logic [7:0] ADDR_SYS_COUNT  = 8'h40;
   localparam logic [7:0] ADDR_TONE_COUNT = 8'h42;
   localparam logic [7:0] ADDR_CTRL_WORD  = 8'h43;

   // Control word field positions.
   localparam int SEL_HI    = 7;
   localparam int SEL_LO    = 6;
   localparam int ACC_HI    = 5;
   localparam int ACC_LO    = 4;
   localparam int MODE_HI   = 3;
   localparam int MODE_LO   = 1;
   localparam int BCD_BIT   = 0;

   // Counter select codes in bits 7:6.
   localparam logic [1:0] SEL_SYS  = 2'h0;
   localparam logic [1:0] SEL_TONE = 2'h2;
   localparam logic [1:0] SEL_RDBK = 2'h3;

   // Access formats in bits 5:4; zero means a latch command.
   localparam logic [1:0] ACC_LATCH = 2'h0;
   localparam logic [1:0] ACC_LSB   = 2'h1;
   localparam logic [1:0] ACC_MSB   = 2'h2;
   localparam logic [1:0] ACC_WORD  = 2'h3;

   // Read-back command bits: bit 5 low latches count, bit 4 low latches status.
   localparam int RB_NCOUNT  = 5;
   localparam int RB_NSTATUS = 4;
   localparam int RB_CNT0    = 1;
   localparam int RB_CNT2    = 3;

   // Status byte layout.
   localparam int ST_OUT  = 7;
   localparam int ST_NULL = 6;

   // Timing: counter clock and system clock.
   localparam int CNT_CLK_HZ = 1193182;
   localparam int SYS_CLK_HZ = 50000000;
   localparam int CNT_PERIOD_NS = 838;
   localparam int SYS_PERIOD_NS = 20;
   // Divider ratio is the counter period over the clock period, rounded to nearest.
   localparam int TICK_DIV = (CNT_PERIOD_NS + SYS_PERIOD_NS / 2) / SYS_PERIOD_NS;

   // Mode codes.
   localparam logic [2:0] MODE_EOC    = 3'h0;
   localparam logic [2:0] MODE_ONESHOT= 3'h1;
   localparam logic [2:0] MODE_RATE   = 3'h2;
   localparam logic [2:0] MODE_SQUARE = 3'h3;
   localparam logic [2:0] MODE_SWSTB  = 3'h4;
   localparam logic [2:0] MODE_HWSTB  = 3'h5;

   // Host I/O access carrier.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lit_io_req_t;

endpackage

/* hw/lit_timer.sv */
// Top of the legacy interval timer: port decode, tick divider and two counters.
`timescale 1ns/1ps
`default_nettype none
//Behaviour
// - Counters step every 42 clocks (840 ns) from divider.
// - System counter square wave drives tick irq.
// - Written count loads at the next counter tick; modes 1/5 load it at the first gate rise after that tick.
// - Square wave decrements by two, reloads, inverts.
// - Tone frequency is counter clock over count; odd mode 3 counts divide by count plus one.
// - Bits 5:4 choose count byte format.
// - New count anytime keeps programmed mode.
// - Port 43h decodes control, latch, read-back.
// - Mode 0 low, high at zero, stays.
// - Mode 1 low, high one clock at zero.
// - Mode 2 high, low one clock, reload.
// - Mode 3 starts high, inverts each rollover.
// - Modes 4/5 high, low one clock on expiry.
// - Direct read returns live count.
// - Other counters accessible between two byte reads.
// - Latch holds count until read or reprogram.
// - Second latch before read is ignored.
// - Read-back latches selected counters together.
// - Repeated unread latches are ignored.
// - Status first, then count, then live.
module lit_timer
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire lit_pkg::lit_io_req_t io_req,
   input  wire logic              tone_gate,
   output logic            [7:0]  io_rdata,
   output logic                   system_tick_irq,
   output logic                   tone_out
);

   localparam int DW = $clog2(lit_pkg::TICK_DIV + 1);

   logic [DW-1:0] div_ff;
   logic          tick_ff;
   logic          hit_sys;
   logic          hit_tone;
   logic          hit_ctrl;
   logic          ctrl_sys;
   logic          ctrl_tone;
   logic          lat_sys;
   logic          lat_tone;
   logic          st_sys;
   logic          st_tone;
   logic [7:0]    rd_sys;
   logic [7:0]    rd_tone;
   logic          out_sys;
   logic          out_tone;
   logic [1:0]    sel;
   logic [1:0]    acc;
   logic          rb;
   logic [7:0]    wd;

   // Counter clock enable: 50 MHz over 42 gives about 1.19 MHz; the small
   // rate error against the crystal-derived clock is the cost of one clock.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end
      else if (div_ff == DW'(lit_pkg::TICK_DIV - 1))
      begin
         div_ff <= '0;
         tick_ff <= 1'b1;
      end
      else
      begin
         div_ff <= div_ff + DW'(1);
         tick_ff <= 1'b0;
      end
   end

   // Address and command decode of the control port.
   assign wd = io_req.wdata;
   assign sel = wd[lit_pkg::SEL_HI:lit_pkg::SEL_LO];
   assign acc = wd[lit_pkg::ACC_HI:lit_pkg::ACC_LO];
   assign hit_sys = io_req.addr == lit_pkg::ADDR_SYS_COUNT;
   assign hit_tone = io_req.addr == lit_pkg::ADDR_TONE_COUNT;
   assign hit_ctrl = io_req.wr && io_req.addr == lit_pkg::ADDR_CTRL_WORD;
   assign rb = hit_ctrl && sel == lit_pkg::SEL_RDBK;
   assign ctrl_sys = hit_ctrl && sel == lit_pkg::SEL_SYS && acc != lit_pkg::ACC_LATCH;
   assign ctrl_tone = hit_ctrl && sel == lit_pkg::SEL_TONE && acc != lit_pkg::ACC_LATCH;
   // Read-back selects several counters at once.
   assign lat_sys = (hit_ctrl && sel == lit_pkg::SEL_SYS && acc == lit_pkg::ACC_LATCH)
                  || (rb && !wd[lit_pkg::RB_NCOUNT] && wd[lit_pkg::RB_CNT0]);
   assign lat_tone = (hit_ctrl && sel == lit_pkg::SEL_TONE && acc == lit_pkg::ACC_LATCH)
                   || (rb && !wd[lit_pkg::RB_NCOUNT] && wd[lit_pkg::RB_CNT2]);
   assign st_sys = rb && !wd[lit_pkg::RB_NSTATUS] && wd[lit_pkg::RB_CNT0];
   assign st_tone = rb && !wd[lit_pkg::RB_NSTATUS] && wd[lit_pkg::RB_CNT2];

   // System timer counter; its gate is always open.
   lit_counter u_sys
   (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .tick      (tick_ff),
      .gate      (1'b1),
      .ctrl_wr   (ctrl_sys),
      .ctrl_data (wd),
      .latch_cnt (lat_sys),
      .latch_st  (st_sys),
      .data_wr   (io_req.wr && hit_sys),
      .data_rd   (io_req.rd && hit_sys),
      .wdata     (wd),
      .rdata     (rd_sys),
      .out       (out_sys)
   );

   // Tone counter; its gate comes from the external control port.
   lit_counter u_tone
   (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .tick      (tick_ff),
      .gate      (tone_gate),
      .ctrl_wr   (ctrl_tone),
      .ctrl_data (wd),
      .latch_cnt (lat_tone),
      .latch_st  (st_tone),
      .data_wr   (io_req.wr && hit_tone),
      .data_rd   (io_req.rd && hit_tone),
      .wdata     (wd),
      .rdata     (rd_tone),
      .out       (out_tone)
   );

   // Outputs registered; read data mux follows the address.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         io_rdata <= 8'h00;
         system_tick_irq <= 1'b0;
         tone_out <= 1'b0;
      end
      else
      begin
         io_rdata <= hit_tone ? rd_tone : (hit_sys ? rd_sys : 8'h00);
         system_tick_irq <= out_sys;
         tone_out <= out_tone;
      end
   end

endmodule
`default_nettype wire

/* sim/lit_timer_checker.sv */
// Concurrent checker for the interval timer top, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module lit_timer_checker
(
   input wire logic                 clk_sys,
   input wire logic                 sys_rst,
   input wire lit_pkg::lit_io_req_t io_req,
   input wire logic                 tone_gate,
   input wire logic [7:0]           io_rdata,
   input wire logic                 system_tick_irq,
   input wire logic                 tone_out
);
   localparam int TICK = lit_pkg::TICK_DIV;

   logic       cw_wr;
   logic [2:0] raw_mode;
   logic [2:0] cw_mode;
   logic       tone_cw;
   logic       sys_cw;
   logic       tone_cnt_wr;
   logic       sys_cnt_wr;
   logic [2:0] tone_mode_ff;
   logic [2:0] sys_mode_ff;
   logic [1:0] tone_dirty_ff;
   logic [1:0] sys_dirty_ff;
   int         tone_run_ff;
   int         sys_run_ff;
   int         sys_prev_ff;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // Decode of control words; modes 6 and 7 fold onto 2 and 3 as the design does.
   assign cw_wr       = io_req.wr && io_req.addr == lit_pkg::ADDR_CTRL_WORD
                        && io_req.wdata[5:4] != lit_pkg::ACC_LATCH;
   assign raw_mode    = io_req.wdata[lit_pkg::MODE_HI:lit_pkg::MODE_LO];
   assign cw_mode     = (raw_mode[2] && raw_mode[1]) ? {1'b0, raw_mode[1:0]} : raw_mode;
   assign tone_cw     = cw_wr && io_req.wdata[7:6] == lit_pkg::SEL_TONE;
   assign sys_cw      = cw_wr && io_req.wdata[7:6] == lit_pkg::SEL_SYS;
   assign tone_cnt_wr = io_req.wr && io_req.addr == lit_pkg::ADDR_TONE_COUNT;
   assign sys_cnt_wr  = io_req.wr && io_req.addr == lit_pkg::ADDR_SYS_COUNT;

   // Programmed mode of each counter, tracked from the host writes.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         tone_mode_ff <= 3'h0;
         sys_mode_ff  <= 3'h0;
      end
      else
      begin
         if (tone_cw)
            tone_mode_ff <= cw_mode;
         if (sys_cw)
            sys_mode_ff <= cw_mode;
      end
   end

   // Any write or gate move makes the next level runs partial, so width checks wait.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         tone_dirty_ff <= 2'h1;
         sys_dirty_ff  <= 2'h2;
      end
      else
      begin
         if (tone_cw || tone_cnt_wr || $changed(tone_gate))
            tone_dirty_ff <= 2'h1;
         else if ($changed(tone_out) && tone_dirty_ff != 2'h0)
            tone_dirty_ff <= tone_dirty_ff - 2'h1;
         if (sys_cw || sys_cnt_wr)
            sys_dirty_ff <= 2'h2;
         else if ($changed(system_tick_irq) && sys_dirty_ff != 2'h0)
            sys_dirty_ff <= sys_dirty_ff - 2'h1;
      end
   end

   // Length of the level run that ends at each output change.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         tone_run_ff <= 0;
         sys_run_ff  <= 0;
         sys_prev_ff <= 0;
      end
      else
      begin
         tone_run_ff <= $changed(tone_out) ? 1 : tone_run_ff + 1;
         sys_run_ff  <= $changed(system_tick_irq) ? 1 : sys_run_ff + 1;
         if ($changed(system_tick_irq))
            sys_prev_ff <= sys_run_ff;
      end
   end

   chk_sys_square_high: assert property (sys_cw && cw_mode == 3'h3 |-> ##[1:2] system_tick_irq)
      else $error("system tick line not high after square wave setup");
   chk_tone_idle_high: assert property (tone_cw && cw_mode inside {3'h2, 3'h3, 3'h4, 3'h5}
      |-> ##[1:2] tone_out)
      else $error("tone output not high after setup");
   chk_tone_start_low: assert property (tone_cw && cw_mode inside {3'h0, 3'h1}
      |-> ##[1:2] !tone_out)
      else $error("tone output not low after setup");
   chk_end_count_hold: assert property (tone_mode_ff == 3'h0 && tone_dirty_ff == 2'h0 && tone_out
      && !tone_cw && !tone_cnt_wr |=> tone_out)
      else $error("end of count output dropped without reprogramming");
   chk_low_pulse_width: assert property ($rose(tone_out) && tone_dirty_ff == 2'h0
      && tone_mode_ff inside {3'h2, 3'h4, 3'h5} |-> tone_run_ff == TICK)
      else $error("low pulse not one counter period wide");
   chk_high_pulse_width: assert property ($fell(tone_out) && tone_dirty_ff == 2'h0
      && tone_mode_ff == 3'h1 |-> tone_run_ff == TICK)
      else $error("one-shot high pulse not one counter period wide");
   chk_square_halves: assert property ($changed(system_tick_irq) && sys_dirty_ff == 2'h0
      && sys_mode_ff == 3'h3 |-> sys_run_ff == sys_prev_ff)
      else $error("system tick square wave halves differ");
   chk_unmapped_zero: assert property (io_req.rd && io_req.addr == 8'h41 ##1 io_req.addr == 8'h41
      |=> io_rdata == 8'h00)
      else $error("unmapped port read returned nonzero");

   cover property (tone_cw && cw_mode == 3'h2);
   cover property ($changed(system_tick_irq) && sys_dirty_ff == 2'h0 && sys_mode_ff == 3'h3);
   cover property ($rose(tone_out) && tone_dirty_ff == 2'h0 && tone_mode_ff == 3'h5);
endmodule

bind lit_timer lit_timer_checker chk_u
(
   .clk_sys         (clk_sys),
   .sys_rst         (sys_rst),
   .io_req          (io_req),
   .tone_gate       (tone_gate),
   .io_rdata        (io_rdata),
   .system_tick_irq (system_tick_irq),
   .tone_out        (tone_out)
);
`default_nettype wire

/* sim/lit_timer_bench.sv */
// Self-checking testbench for the interval timer over its byte-wide port bus.
`timescale 1ns/1ps
`default_nettype none
module lit_timer_bench;
   localparam int CYC_LIMIT = 50000;
   localparam int T = lit_pkg::TICK_DIV;
   localparam logic [7:0] CW  = lit_pkg::ADDR_CTRL_WORD;
   localparam logic [7:0] TNE = lit_pkg::ADDR_TONE_COUNT;
   // Per entry: control word, count, level measured, expected width in counter periods.
   localparam logic [31:0] TBL [9] = '{32'h9400_0401, 32'h9400_0413, 32'h9600_0603,
      32'h9600_0613, 32'h9800_0301, 32'h9A00_0301, 32'h9200_0311, 32'h3600_0A15, 32'h3600_0A05};

   logic                 clk_sys   = 1'b0;
   logic                 sys_rst   = 1'b1;
   lit_pkg::lit_io_req_t io_req    = '0;
   logic                 tone_gate = 1'b1;
   logic [7:0]           io_rdata;
   logic                 system_tick_irq;
   logic                 tone_out;
   int                   err_total = 0;
   int                   cmp_count = 0;
   int                   cyc       = 0;
   int                   n;

   lit_timer dut_u
   (
      .clk_sys         (clk_sys),
      .sys_rst         (sys_rst),
      .io_req          (io_req),
      .tone_gate       (tone_gate),
      .io_rdata        (io_rdata),
      .system_tick_irq (system_tick_irq),
      .tone_out        (tone_out)
   );

   // Free-running 50 MHz clock.
   always #10 clk_sys = ~clk_sys;

   task automatic stop_test();
      if (err_total == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hang guard: a run far past the expected length counts as a mismatch.
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == CYC_LIMIT)
      begin
         err_total++;
         stop_test();
      end
   end

   task automatic check8(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe; the strobe drops at the same edge that takes it.
   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      io_req.wr <= 1'b0;
   endtask

   // Read data lands one edge after the taking edge, so the address is held until then.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys);
      io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      io_req.rd <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check8(what, io_rdata, exp);
   endtask

   // Count bytes follow the control word's format and go out with no other writer between.
   task automatic wr_count(input logic [7:0] cw_val, input logic [15:0] cnt);
      logic [7:0] port;
      port = cw_val[7] ? TNE : lit_pkg::ADDR_SYS_COUNT;
      if (cw_val[lit_pkg::ACC_LO]) io_wr(port, cnt[7:0]);
      if (cw_val[lit_pkg::ACC_HI]) io_wr(port, cnt[15:8]);
   endtask

   task automatic ticks(input int k);
      repeat (k * T) @(posedge clk_sys);
   endtask

   // Width in clocks of the next full run at level lvl, sampled mid-cycle; -1 on hang.
   task automatic run_len(input logic tone, input logic lvl, output int w);
      int k;
      k = 0;
      w = 0;
      while (((tone ? tone_out : system_tick_irq) === lvl) && k < 4000)
      begin
         @(negedge clk_sys);
         k++;
      end
      while (((tone ? tone_out : system_tick_irq) !== lvl) && k < 4000)
      begin
         @(negedge clk_sys);
         k++;
      end
      while (((tone ? tone_out : system_tick_irq) === lvl) && k < 4000)
      begin
         @(negedge clk_sys);
         k++;
         w++;
      end
      if (k >= 4000)
         w = -1;
   endtask

   // Main sequence: reset, latching and read-back on a stopped counter, then output waveforms.
   initial
   begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      check8("rdata after reset", io_rdata, 8'h00);
      check8("irq after reset", {7'h00, system_tick_irq}, 8'h00);
      check8("tone after reset", {7'h00, tone_out}, 8'h00);
      @(posedge clk_sys);
      tone_gate <= 1'b0;
      io_wr(CW, 8'hB0);
      wr_count(8'hB0, 16'h1234);
      ticks(3);
      rd_chk(TNE, 8'h34, "live low");
      rd_chk(TNE, 8'h12, "live high");
      io_wr(CW, 8'h80);
      wr_count(8'hB0, 16'h5678);
      ticks(3);
      io_wr(CW, 8'h80);
      rd_chk(TNE, 8'h34, "latched low");
      rd_chk(8'h41, 8'h00, "unmapped port");
      rd_chk(TNE, 8'h12, "latched high");
      rd_chk(TNE, 8'h78, "new count low");
      rd_chk(TNE, 8'h56, "new count high");
      io_wr(CW, 8'hCA);
      wr_count(8'hB0, 16'h0102);
      ticks(3);
      io_wr(CW, 8'hC8);
      rd_chk(TNE, 8'h30, "tone status");
      rd_chk(TNE, 8'h78, "readback low");
      rd_chk(TNE, 8'h56, "readback high");
      rd_chk(TNE, 8'h02, "unlatched low");
      rd_chk(TNE, 8'h01, "unlatched high");
      rd_chk(lit_pkg::ADDR_SYS_COUNT, 8'h50, "system status");
      @(posedge clk_sys);
      tone_gate <= 1'b1;
      io_wr(CW, 8'hB0);
      wr_count(8'hB0, 16'h0003);
      @(negedge clk_sys);
      check8("mode 0 start", {7'h00, tone_out}, 8'h00);
      ticks(8);
      @(negedge clk_sys);
      check8("mode 0 end", {7'h00, tone_out}, 8'h01);
      ticks(8);
      @(negedge clk_sys);
      check8("mode 0 hold", {7'h00, tone_out}, 8'h01);
      // A BCD count of 0010 expires after ten ticks; binary would need sixteen.
      io_wr(CW, 8'hB1);
      wr_count(8'hB1, 16'h0010);
      ticks(13);
      @(negedge clk_sys);
      check8("bcd expiry", {7'h00, tone_out}, 8'h01);
      foreach (TBL[i])
      begin
         @(posedge clk_sys);
         tone_gate <= 1'b0;
         io_wr(CW, TBL[i][31:24]);
         wr_count(TBL[i][31:24], TBL[i][23:8]);
         ticks(2);
         tone_gate <= 1'b1;
         run_len(TBL[i][31], TBL[i][4], n);
         check8("run width", (n > 255) ? 8'hFF : n[7:0],
                8'(32'(TBL[i][3:0]) * T));
      end
      stop_test();
   end
endmodule
`default_nettype wire
